// [rtl/psp_pkg.sv]
// Shared constants and types for the parallel slave port and its host.
// Assumes both ends run on one 200 MHz clock.
package psp_pkg;

   // ******************************************************************
   // Register indices of the local CPU port
   // ******************************************************************
   typedef logic [3:0] reg_idx_t;
   typedef logic [7:0] byte_t;
   localparam reg_idx_t IDX_DIR_STATUS = 4'h0;
   localparam reg_idx_t IDX_CTRL_PINS  = 4'h1;
   localparam reg_idx_t IDX_CTRL_LATCH = 4'h2;
   localparam reg_idx_t IDX_ANALOG_CFG = 4'h3;
   localparam reg_idx_t IDX_DATA_PORT  = 4'h4;
   localparam reg_idx_t IDX_DATA_LATCH = 4'h5;
   localparam reg_idx_t IDX_DATA_DIR   = 4'h6;
   localparam reg_idx_t IDX_CORE_IRQ   = 4'h7;
   localparam reg_idx_t IDX_IRQ_FLAGS  = 4'h8;
   localparam reg_idx_t IDX_IRQ_EN     = 4'h9;
   localparam reg_idx_t IDX_IRQ_PRIO   = 4'hA;

   // ******************************************************************
   // Field positions and reset values
   // ******************************************************************
   localparam int BIT_IN_FULL  = 7;
   localparam int BIT_OUT_FULL = 6;
   localparam int BIT_IN_OVF   = 5;
   localparam int BIT_MODE    = 4;
   localparam int BIT_SP_IRQ  = 7;
   localparam int BIT_GIE     = 7;
   localparam int BIT_PEIE    = 6;
   localparam int PIN_RD      = 0;
   localparam int PIN_WR      = 1;
   localparam int PIN_CS      = 2;
   localparam logic [2:0] RST_CTRL_DIR  = 3'h7;
   localparam byte_t      RST_DATA_DIR  = 8'hFF;
   localparam byte_t      RST_ZERO      = 8'h00;
   localparam logic [2:0] CTRL_IDLE     = 3'h7;
   localparam logic [1:0] DIGITAL_CFG   = 2'h3;

   // ******************************************************************
   // Host strobe timing
   // ******************************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int STROBE_NS     = 40;
   localparam int GAP_NS        = 20;
   localparam logic [3:0] STROBE_CYC =
      4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] GAP_CYC =
      4'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_STROBE = 2'b01,
      H_GAP    = 2'b11
   } host_state_t;

endpackage : psp_pkg

// [rtl/psp_link_if.sv]
// Pin bundle between the slave port device and the external host.
// Assumes a pull-up on every line: an undriven line reads as one.
`timescale 1ns/1ps
interface psp_link_if;
   logic [2:0] hostCtrlOut;
   logic [2:0] hostCtrlOen;
   logic [2:0] devCtrlOut;
   logic [2:0] devCtrlOen;
   logic [7:0] hostDataOut;
   logic [7:0] hostDataOen;
   logic [7:0] devDataOut;
   logic [7:0] devDataOen;
   logic [2:0] ctrlWire;
   logic [7:0] dataWire;

   // Enables are low while driving; the device wins a clash.
   assign ctrlWire = (~devCtrlOen & devCtrlOut)
                   | (devCtrlOen & ~hostCtrlOen & hostCtrlOut)
                   | (devCtrlOen & hostCtrlOen);
   assign dataWire = (~devDataOen & devDataOut)
                   | (devDataOen & ~hostDataOen & hostDataOut)
                   | (devDataOen & hostDataOen);

   modport dev  (input ctrlWire, dataWire,
                 output devCtrlOut, devCtrlOen, devDataOut, devDataOen);
   modport host (input ctrlWire, dataWire,
                 output hostCtrlOut, hostCtrlOen, hostDataOut,
                 hostDataOen);
endinterface : psp_link_if

// [rtl/psp_device.sv]
// Parallel slave port device: data port, control port and status.
// Assumes the local CPU reaches registers through regIdx/regWr/regRd,
// and that the link pins are asynchronous to clk.
// Behaviour
// - Input-full flag shows unread host byte
// - Output-full flag set until host reads
// - Overflow on host write while unread; sticky
// - Mode bit selects slave port or GPIO
// - Direction bit one makes pin input
// - Status bit 3 reads zero always
// - Read strobe low with select reads
// - Write strobe low with select writes
// - Chip select is active low
// - Mode set makes 8-bit async slave
// - Pins 0,1,2 are read, write, select
// - Software sets pins input and digital
// - Write taken at first select+write low
// - Read taken when select+read low ends
// - Host sees one 8-bit latch
// - Control port has three bits, reset zero
// - Analog-configured pins read as zero
// - Direction bits drive pins even analog
`timescale 1ns/1ps
module psp_device (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   psp_link_if.dev               link,
   input  wire psp_pkg::reg_idx_t regIdx,
   input  wire logic             regWr,
   input  wire logic             regRd,
   input  wire psp_pkg::byte_t   regWdata,
   output logic [7:0]            regRdata,
   output logic                  irqReq,
   output logic                  irqHigh
);
   import psp_pkg::*;

   // ******************************************************************
   // State
   // ******************************************************************
   logic [2:0] ctrlS1_ff, ctrlS2_ff;
   byte_t      dataS1_ff, dataS2_ff;
   logic       prevRd_ff, prevWr_ff;
   logic       inFull_ff, outFull_ff, inOvf_ff, mode_ff;
   logic [2:0] ctrlDir_ff, ctrlLatch_ff;
   byte_t      analogCfg_ff, inBuf_ff, outLatch_ff, dataDir_ff;
   logic [1:0] coreIrq_ff;
   logic       irqFlag_ff, irqEn_ff, irqPrio_ff;
   byte_t      rdata_ff, devDataOut_ff, devDataOen_ff;
   logic [2:0] devCtrlOen_ff;
   logic       irqReq_ff, irqHigh_ff;

   logic       nxt_prevRd, nxt_prevWr;
   logic       nxt_inFull, nxt_outFull, nxt_inOvf, nxt_mode;
   logic [2:0] nxt_ctrlDir, nxt_ctrlLatch;
   byte_t      nxt_analogCfg, nxt_inBuf, nxt_outLatch, nxt_dataDir;
   logic [1:0] nxt_coreIrq;
   logic       nxt_irqFlag, nxt_irqEn, nxt_irqPrio;
   byte_t      nxt_rdata, nxt_devDataOut, nxt_devDataOen;
   logic [2:0] nxt_devCtrlOen;
   logic       nxt_irqReq, nxt_irqHigh;

   logic       rdAct, wrAct, wrStart, wrEnd, rdEnd;
   logic       digital, cpuRdPort, cpuWrPort;
   logic [2:0] pinView;
   byte_t      statusView;

   // ******************************************************************
   // Access detection
   // ******************************************************************
   // Only the second stage is looked at; the first may be metastable.
   // Both strobes share the select term, so a glitch on either line
   // while deselected never counts as an access.
   always_comb begin
      rdAct   = mode_ff & ~ctrlS2_ff[PIN_CS]
              & ~ctrlS2_ff[PIN_RD];
      wrAct   = mode_ff & ~ctrlS2_ff[PIN_CS]
              & ~ctrlS2_ff[PIN_WR];
      wrStart = wrAct & ~prevWr_ff;
      wrEnd   = prevWr_ff & ~wrAct;
      rdEnd   = prevRd_ff & ~rdAct;
      digital = (analogCfg_ff[2:1] == DIGITAL_CFG);
      pinView = digital ? ctrlS2_ff : 3'h0;
      statusView = {inFull_ff, outFull_ff, inOvf_ff, mode_ff,
                    1'b0, ctrlDir_ff};
      cpuRdPort = regRd & (regIdx == IDX_DATA_PORT);
      cpuWrPort = regWr & ((regIdx == IDX_DATA_PORT)
                        | (regIdx == IDX_DATA_LATCH));
   end

   // ******************************************************************
   // Register file and flags
   // ******************************************************************
   always_comb begin
      nxt_prevRd    = rdAct;
      nxt_prevWr    = wrAct;
      nxt_inFull    = inFull_ff;
      nxt_outFull   = outFull_ff;
      nxt_inOvf     = inOvf_ff;
      nxt_mode      = mode_ff;
      nxt_ctrlDir   = ctrlDir_ff;
      nxt_ctrlLatch = ctrlLatch_ff;
      nxt_analogCfg = analogCfg_ff;
      nxt_inBuf     = inBuf_ff;
      nxt_outLatch  = outLatch_ff;
      nxt_dataDir   = dataDir_ff;
      nxt_coreIrq   = coreIrq_ff;
      nxt_irqFlag   = irqFlag_ff;
      nxt_irqEn     = irqEn_ff;
      nxt_irqPrio   = irqPrio_ff;
      nxt_rdata     = rdata_ff;

      // Software writes first, so hardware events below win the cycle.
      if (regWr) begin
         case (regIdx)
            IDX_DIR_STATUS: begin
               nxt_mode    = regWdata[BIT_MODE];
               nxt_ctrlDir = regWdata[2:0];
               if (!regWdata[BIT_IN_OVF]) begin
                  nxt_inOvf = 1'b0;
               end
            end
            IDX_CTRL_PINS,
            IDX_CTRL_LATCH: nxt_ctrlLatch = regWdata[2:0];
            IDX_ANALOG_CFG: nxt_analogCfg = regWdata;
            IDX_DATA_PORT,
            IDX_DATA_LATCH: nxt_outLatch  = regWdata;
            IDX_DATA_DIR:   nxt_dataDir   = regWdata;
            IDX_CORE_IRQ:   nxt_coreIrq   = regWdata[7:6];
            IDX_IRQ_FLAGS:  nxt_irqFlag   = regWdata[BIT_SP_IRQ];
            IDX_IRQ_EN:     nxt_irqEn     = regWdata[BIT_SP_IRQ];
            IDX_IRQ_PRIO:   nxt_irqPrio   = regWdata[BIT_SP_IRQ];
            default: ;
         endcase
      end
      if (mode_ff && cpuRdPort) begin
         nxt_inFull = 1'b0;
      end
      if (mode_ff && cpuWrPort) begin
         nxt_outFull = 1'b1;
      end
      if (rdEnd) begin
         nxt_outFull = 1'b0;
         nxt_irqFlag = 1'b1;
      end
      if (wrStart) begin
         nxt_inBuf = dataS2_ff;
         if (inFull_ff) begin
            nxt_inOvf = 1'b1;
         end
      end
      if (wrEnd) begin
         nxt_inFull  = 1'b1;
         nxt_irqFlag = 1'b1;
      end

      if (regRd) begin
         case (regIdx)
            IDX_DIR_STATUS: nxt_rdata = statusView;
            IDX_CTRL_PINS:  nxt_rdata = {5'h00, pinView};
            IDX_CTRL_LATCH: nxt_rdata = {5'h00, ctrlLatch_ff};
            IDX_ANALOG_CFG: nxt_rdata = analogCfg_ff;
            IDX_DATA_PORT:  nxt_rdata = mode_ff ? inBuf_ff : dataS2_ff;
            IDX_DATA_LATCH: nxt_rdata = outLatch_ff;
            IDX_DATA_DIR:   nxt_rdata = dataDir_ff;
            IDX_CORE_IRQ:   nxt_rdata = {coreIrq_ff, 6'h00};
            IDX_IRQ_FLAGS:  nxt_rdata = {irqFlag_ff, 7'h00};
            IDX_IRQ_EN:     nxt_rdata = {irqEn_ff, 7'h00};
            IDX_IRQ_PRIO:   nxt_rdata = {irqPrio_ff, 7'h00};
            default:        nxt_rdata = RST_ZERO;
         endcase
      end
   end

   // ******************************************************************
   // Pin drivers and interrupt request
   // ******************************************************************
   always_comb begin
      nxt_devCtrlOen = ctrlDir_ff;
      nxt_devDataOut = outLatch_ff;
      if (mode_ff) begin
         nxt_devDataOen = rdAct ? 8'h00 : 8'hFF;
      end else begin
         nxt_devDataOen = dataDir_ff;
      end
      nxt_irqReq  = nxt_irqFlag & nxt_irqEn
                  & nxt_coreIrq[BIT_GIE - 6]
                  & nxt_coreIrq[BIT_PEIE - 6];
      nxt_irqHigh = nxt_irqReq & nxt_irqPrio;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrlS1_ff     <= CTRL_IDLE;
         ctrlS2_ff     <= CTRL_IDLE;
         dataS1_ff     <= RST_ZERO;
         dataS2_ff     <= RST_ZERO;
         prevRd_ff     <= 1'b0;
         prevWr_ff     <= 1'b0;
         inFull_ff     <= 1'b0;
         outFull_ff    <= 1'b0;
         inOvf_ff      <= 1'b0;
         mode_ff       <= 1'b0;
         ctrlDir_ff    <= RST_CTRL_DIR;
         ctrlLatch_ff  <= 3'h0;
         analogCfg_ff  <= RST_ZERO;
         inBuf_ff      <= RST_ZERO;
         outLatch_ff   <= RST_ZERO;
         dataDir_ff    <= RST_DATA_DIR;
         coreIrq_ff    <= 2'h0;
         irqFlag_ff    <= 1'b0;
         irqEn_ff      <= 1'b0;
         irqPrio_ff    <= 1'b0;
         rdata_ff      <= RST_ZERO;
         devDataOut_ff <= RST_ZERO;
         devDataOen_ff <= RST_DATA_DIR;
         devCtrlOen_ff <= RST_CTRL_DIR;
         irqReq_ff     <= 1'b0;
         irqHigh_ff    <= 1'b0;
      end else if (ce) begin
         ctrlS1_ff     <= link.ctrlWire;
         ctrlS2_ff     <= ctrlS1_ff;
         dataS1_ff     <= link.dataWire;
         dataS2_ff     <= dataS1_ff;
         prevRd_ff     <= nxt_prevRd;
         prevWr_ff     <= nxt_prevWr;
         inFull_ff     <= nxt_inFull;
         outFull_ff    <= nxt_outFull;
         inOvf_ff      <= nxt_inOvf;
         mode_ff       <= nxt_mode;
         ctrlDir_ff    <= nxt_ctrlDir;
         ctrlLatch_ff  <= nxt_ctrlLatch;
         analogCfg_ff  <= nxt_analogCfg;
         inBuf_ff      <= nxt_inBuf;
         outLatch_ff   <= nxt_outLatch;
         dataDir_ff    <= nxt_dataDir;
         coreIrq_ff    <= nxt_coreIrq;
         irqFlag_ff    <= nxt_irqFlag;
         irqEn_ff      <= nxt_irqEn;
         irqPrio_ff    <= nxt_irqPrio;
         rdata_ff      <= nxt_rdata;
         devDataOut_ff <= nxt_devDataOut;
         devDataOen_ff <= nxt_devDataOen;
         devCtrlOen_ff <= nxt_devCtrlOen;
         irqReq_ff     <= nxt_irqReq;
         irqHigh_ff    <= nxt_irqHigh;
      end
   end

   assign link.devCtrlOut = ctrlLatch_ff;
   assign link.devCtrlOen = devCtrlOen_ff;
   assign link.devDataOut = devDataOut_ff;
   assign link.devDataOen = devDataOen_ff;
   assign regRdata        = rdata_ff;
   assign irqReq          = irqReq_ff;
   assign irqHigh         = irqHigh_ff;

endmodule : psp_device

// [rtl/psp_host.sv]
// External microprocessor end: turns byte commands into strobe cycles.
// Assumes the device side is configured for slave port mode.
`timescale 1ns/1ps
module psp_host (
   input  wire logic           clk,
   input  wire logic           sys_rst,
   input  wire logic           ce,
   psp_link_if.host            link,
   input  wire logic           cmdValid,
   input  wire logic           cmdWrite,
   input  wire psp_pkg::byte_t cmdData,
   output logic                cmdReady,
   output logic                rspValid,
   output logic [7:0]          rspData,
   input  wire logic           rspReady
);
   import psp_pkg::*;

   host_state_t state_ff, nxt_state;
   logic [3:0]  cnt_ff, nxt_cnt;
   logic        isWr_ff, nxt_isWr;
   logic [2:0]  ctrlOut_ff, nxt_ctrlOut;
   byte_t       dataOut_ff, nxt_dataOut, dataOen_ff, nxt_dataOen;
   byte_t       dataS1_ff, dataS2_ff;
   logic        hv_ff, nxt_hv, sv_ff, nxt_sv;
   byte_t       hd_ff, nxt_hd, sd_ff, nxt_sd;
   logic        ready_ff, nxt_ready;
   logic        push;

   // ******************************************************************
   // Strobe engine and two-entry read buffer
   // ******************************************************************
   // A read starts only while the spare slot is free, so its result
   // always finds room; a stalled reader therefore stalls new commands.
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_isWr    = isWr_ff;
      nxt_ctrlOut = ctrlOut_ff;
      nxt_dataOut = dataOut_ff;
      nxt_dataOen = dataOen_ff;
      push        = 1'b0;
      case (state_ff)
         H_IDLE: begin
            if (cmdValid && ready_ff) begin
               nxt_isWr = cmdWrite;
               nxt_ctrlOut[PIN_CS] = 1'b0;
               nxt_ctrlOut[PIN_WR] = ~cmdWrite;
               nxt_ctrlOut[PIN_RD] = cmdWrite;
               nxt_dataOut = cmdData;
               nxt_dataOen = cmdWrite ? 8'h00 : 8'hFF;
               nxt_cnt     = STROBE_CYC - 4'h1;
               nxt_state   = H_STROBE;
            end
         end
         H_STROBE: begin
            if (cnt_ff == 4'h0) begin
               push        = ~isWr_ff;
               nxt_ctrlOut = CTRL_IDLE;
               nxt_dataOen = 8'hFF;
               nxt_cnt     = GAP_CYC - 4'h1;
               nxt_state   = H_GAP;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         H_GAP: begin
            if (cnt_ff == 4'h0) begin
               nxt_state = H_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         default: begin
            nxt_ctrlOut = CTRL_IDLE;
            nxt_dataOen = 8'hFF;
            nxt_state   = H_IDLE;
         end
      endcase

      nxt_hv = hv_ff;
      nxt_sv = sv_ff;
      nxt_hd = hd_ff;
      nxt_sd = sd_ff;
      if (hv_ff && rspReady) begin
         if (sv_ff) begin
            nxt_hd = sd_ff;
            nxt_sv = 1'b0;
         end else begin
            nxt_hv = 1'b0;
         end
      end
      if (push) begin
         if (!nxt_hv) begin
            nxt_hv = 1'b1;
            nxt_hd = dataS2_ff;
         end else begin
            nxt_sv = 1'b1;
            nxt_sd = dataS2_ff;
         end
      end
      nxt_ready = (nxt_state == H_IDLE) && !nxt_sv;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff   <= H_IDLE;
         cnt_ff     <= 4'h0;
         isWr_ff    <= 1'b0;
         ctrlOut_ff <= CTRL_IDLE;
         dataOut_ff <= RST_ZERO;
         dataOen_ff <= 8'hFF;
         dataS1_ff  <= RST_ZERO;
         dataS2_ff  <= RST_ZERO;
         hv_ff      <= 1'b0;
         sv_ff      <= 1'b0;
         hd_ff      <= RST_ZERO;
         sd_ff      <= RST_ZERO;
         ready_ff   <= 1'b0;
      end else if (ce) begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         isWr_ff    <= nxt_isWr;
         ctrlOut_ff <= nxt_ctrlOut;
         dataOut_ff <= nxt_dataOut;
         dataOen_ff <= nxt_dataOen;
         dataS1_ff  <= link.dataWire;
         dataS2_ff  <= dataS1_ff;
         hv_ff      <= nxt_hv;
         sv_ff      <= nxt_sv;
         hd_ff      <= nxt_hd;
         sd_ff      <= nxt_sd;
         ready_ff   <= nxt_ready;
      end
   end

   assign link.hostCtrlOut = ctrlOut_ff;
   assign link.hostCtrlOen = 3'h0;
   assign link.hostDataOut = dataOut_ff;
   assign link.hostDataOen = dataOen_ff;
   assign cmdReady         = ready_ff;
   assign rspValid         = hv_ff;
   assign rspData          = hd_ff;

endmodule : psp_host

// [dv/psp_chk.sv]
// Checker for the pins that join the slave port device to its host.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module psp_chk (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [2:0] hostCtrlOut,
   input wire logic [2:0] hostCtrlOen,
   input wire logic [7:0] hostDataOen,
   input wire logic [7:0] devDataOen,
   input wire logic [2:0] ctrlWire
);
   // ******************************************************************
   // Strobe framing and data drive on the link
   // ******************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_strobe_len: assert property ($fell(hostCtrlOut[2]) |->
      (!hostCtrlOut[2]) [*8] ##1 hostCtrlOut[2])
      else $error("select low time is not eight cycles");
   a_gap_min: assert property ($rose(hostCtrlOut[2]) |->
      hostCtrlOut[2] [*4]) else $error("select gap too short");
   a_strobe_idle: assert property (hostCtrlOut[2] |->
      hostCtrlOut[1:0] == 2'b11) else $error("strobe without select");
   a_one_strobe: assert property (!hostCtrlOut[2] |->
      hostCtrlOut[1] != hostCtrlOut[0]) else $error("strobe pair wrong");
   a_ctrl_driven: assert property (hostCtrlOen == 3'h0 &&
      ctrlWire == hostCtrlOut) else $error("control lines not host's");
   a_write_data: assert property (!hostCtrlOut[2] && !hostCtrlOut[1] |->
      hostDataOen == 8'h00) else $error("host data not driven in write");
   a_read_float: assert property (!hostCtrlOut[2] && !hostCtrlOut[0] |->
      hostDataOen == 8'hFF) else $error("host drives data in read");
   a_drive_start: assert property ($fell(ctrlWire[0]) && !ctrlWire[2] |->
      ##[2:4] (devDataOen == 8'h00) [*4]) else $error("read not answered");
   a_drive_release: assert property ($rose(ctrlWire[0]) |->
      ##[1:4] devDataOen == 8'hFF) else $error("data not released");
   a_drive_cause: assert property ($fell(devDataOen[0]) |->
      !ctrlWire[2] && !ctrlWire[0]) else $error("drive without read");
   a_no_clash: assert property (devDataOen != 8'hFF |->
      hostDataOen == 8'hFF) else $error("both ends drive data");

   c_write: cover property ($fell(hostCtrlOut[1]) && !hostCtrlOut[2]);
   c_read: cover property ($fell(hostCtrlOut[0]) && !hostCtrlOut[2]);
   c_drive: cover property ($fell(devDataOen[0]));
endmodule : psp_chk

// [dv/testbench.sv]
// Self-checking bench: device and host end joined by the link.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
module testbench;
   import psp_pkg::*;
   // ******************************************************************
   // Stimulus, wiring and result monitors
   // ******************************************************************
   logic       clk      = 1'b0;
   logic       sys_rst  = 1'b1;
   logic       ce       = 1'b1;
   reg_idx_t   regIdx   = 4'h0;
   logic       regWr    = 1'b0;
   logic       regRd    = 1'b0;
   byte_t      regWdata = 8'h00;
   logic [7:0] regRdata;
   logic       irqReq;
   logic       irqHigh;
   logic       cmdValid = 1'b0;
   logic       cmdWrite = 1'b0;
   byte_t      cmdData  = 8'h00;
   logic       cmdReady;
   logic       rspValid;
   logic [7:0] rspData;
   logic       rspReady = 1'b0;
   logic [8:0] regQ[$];
   byte_t      rspQ[$];
   logic [8:0] note;
   logic       rdPipe   = 1'b0;
   int         num_errors = 0;
   int         checks   = 0;
   int         cycles   = 0;
   integer     seed     = 6111;
   byte_t      dat;

   always #2.5 clk = ~clk;

   psp_link_if link ();
   psp_device u_psp_device (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .link(link), .regIdx(regIdx), .regWr(regWr), .regRd(regRd),
      .regWdata(regWdata), .regRdata(regRdata), .irqReq(irqReq),
      .irqHigh(irqHigh));
   psp_host u_psp_host (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .link(link), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
      .rspData(rspData), .rspReady(rspReady));
   psp_chk u_psp_chk (.clk(clk), .sys_rst(sys_rst),
      .hostCtrlOut(link.hostCtrlOut), .hostCtrlOen(link.hostCtrlOen),
      .hostDataOen(link.hostDataOen), .devDataOen(link.devDataOen),
      .ctrlWire(link.ctrlWire));

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // Called at a falling edge; the strobe stays up for the next call,
   // so only idle() or a call of the other kind lowers it, and no signal is assigned twice at once.
   task automatic reg_op(input logic wr, input reg_idx_t idx,
                         input byte_t d, input logic chk);
      regIdx = idx;
      regWr = wr;
      regRd = ~wr;
      regWdata = d;
      if (!wr)
         regQ.push_back({chk, d});
      @(negedge clk);
   endtask : reg_op

   task automatic idle(input int n);
      regWr = 1'b0;
      regRd = 1'b0;
      cmdValid = 1'b0;
      repeat (n) @(negedge clk);
   endtask : idle

   task automatic host_cmd(input logic wr, input byte_t d);
      cmdValid = 1'b1;
      cmdWrite = wr;
      cmdData = d;
      if (!wr)
         rspQ.push_back(d);
      @(posedge clk);
      while (cmdReady !== 1'b1) @(posedge clk);
      @(negedge clk);
   endtask : host_cmd

   // The result stalls at random so the two-entry buffer fills up.
   always @(negedge clk) rspReady <= 1'($random(seed));
   // Read data is registered at the read edge and stands from then on.
   always @(posedge clk) rdPipe <= regRd & ~sys_rst;

   always @(negedge clk) begin
      if (rdPipe) begin
         note = regQ.pop_front();
         if (note[8])
            check("regRdata", regRdata, note[7:0]);
      end
   end

   always @(posedge clk) begin
      if (!sys_rst && rspValid === 1'b1 && rspReady === 1'b1)
         check("rspData", rspData, rspQ.pop_front());
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      idle(2);
      reg_op(0, IDX_DIR_STATUS, 8'h07, 1);
      reg_op(0, IDX_CTRL_PINS, 8'h00, 1);
      reg_op(0, IDX_DATA_DIR, RST_DATA_DIR, 1);
      reg_op(0, IDX_IRQ_FLAGS, 8'h00, 1);
      reg_op(0, 4'hB, 8'h00, 1);
      reg_op(1, IDX_ANALOG_CFG, 8'h07, 0);
      reg_op(1, IDX_IRQ_EN, 8'h80, 0);
      reg_op(1, IDX_CORE_IRQ, 8'hC0, 0);
      reg_op(1, IDX_IRQ_PRIO, 8'h80, 0);
      reg_op(1, IDX_DIR_STATUS, 8'hFF, 0);
      reg_op(0, IDX_DIR_STATUS, 8'h17, 1);
      reg_op(0, IDX_CTRL_PINS, 8'h07, 1);
      reg_op(1, IDX_CTRL_LATCH, 8'h05, 0);
      reg_op(0, IDX_CTRL_LATCH, 8'h05, 1);
      idle(2);
      for (int i = 0; i < 3; i++) begin
         dat = 8'($random(seed));
         host_cmd(1, dat);
         idle(14);
         check("irqReq", {7'h00, irqReq}, 8'h01);
         check("irqHigh", {7'h00, irqHigh}, 8'h01);
         reg_op(0, IDX_DIR_STATUS, 8'h97, 1);
         reg_op(0, IDX_DATA_PORT, dat, 1);
         reg_op(1, IDX_IRQ_FLAGS, 8'h00, 0);
         reg_op(0, IDX_DIR_STATUS, 8'h17, 1);
         idle(3);
         check("irqReq", {7'h00, irqReq}, 8'h00);
      end
      host_cmd(1, 8'h5A);
      host_cmd(1, 8'hA5);
      idle(14);
      reg_op(0, IDX_DIR_STATUS, 8'hB7, 1);
      reg_op(0, IDX_DIR_STATUS, 8'hB7, 1);
      reg_op(1, IDX_DIR_STATUS, 8'h17, 0);
      reg_op(0, IDX_DIR_STATUS, 8'h97, 1);
      reg_op(0, IDX_DATA_PORT, 8'h00, 0);
      reg_op(1, IDX_IRQ_FLAGS, 8'h00, 0);
      for (int i = 0; i < 4; i++) begin
         dat = 8'($random(seed));
         reg_op(1, IDX_DATA_PORT, dat, 0);
         reg_op(0, IDX_DIR_STATUS, 8'h57, 1);
         host_cmd(0, dat);
         host_cmd(0, dat);
         idle(16);
         reg_op(0, IDX_DIR_STATUS, 8'h17, 1);
      end
      reg_op(1, IDX_DIR_STATUS, 8'h07, 0);
      host_cmd(1, 8'h3C);
      idle(14);
      reg_op(0, IDX_DIR_STATUS, 8'h07, 1);
      idle(20);
      check("pending", 8'(regQ.size() + rspQ.size()), 8'h00);
      stop_test();
   end
endmodule : testbench
